// file: rtl/edo_ctrl_pkg.sv
// Types for the EDO DRAM controller.
// Assumes the timing header is compiled alongside.
package edo_ctrl_pkg;
	typedef enum logic [3:0]
	{
		ST_WAKE_PAUSE = 4'h0,
		ST_IDLE       = 4'h1,
		ST_ROW_OPEN   = 4'h3,
		ST_COL_LOW    = 4'h2,
		ST_COL_HIGH   = 4'h6,
		ST_PRECHARGE  = 4'h7,
		ST_REF_CAS    = 4'h5,
		ST_REF_RAS    = 4'h4,
		ST_REF_END    = 4'hc
	} ctrl_state_t;
endpackage

// file: rtl/edo_ctrl_regs.svh
// Timing constants for the EDO DRAM controller.
// Assumes a 125 MHz sys_clk; counts derive from nanosecond figures.
`ifndef EDO_CTRL_REGS_SVH
`define EDO_CTRL_REGS_SVH

`define CLK_PERIOD_NS      8
`define WAKE_PAUSE_NS      200000
`define WAKE_PAUSE_CYC     ((`WAKE_PAUSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_REFRESHES     8
`define REFRESH_ROWS       1024
`define REFRESH_PERIOD_NS  16000000
`define REFRESH_GAP_CYC    ((`REFRESH_PERIOD_NS / `REFRESH_ROWS) / `CLK_PERIOD_NS)
`define RAS_PRECHARGE_NS   40
`define RAS_PRECHARGE_CYC  ((`RAS_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAS_PULSE_NS       60
`define RAS_PULSE_CYC      ((`RAS_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAS_CAS_NS         20
`define RAS_CAS_CYC        ((`RAS_CAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAS_PULSE_NS       30
`define CAS_PULSE_CYC      ((`CAS_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAS_PRECHARGE_NS   10
`define CAS_PRECHARGE_CYC  ((`CAS_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH         8

`endif

// file: rtl/edo_dram_ctrl.sv
// Host-side controller for a 1M x 16 EDO page-mode DRAM.
// Assumes the DRAM pins are wired directly; the bench resolves the data bus.
`include "edo_ctrl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Wait 200 us after reset, then run eight refreshes before accepting requests.
// - If refresh falls overdue, rerun the eight-refresh wake-up sequence.
// - Each new row starts after both strobes are high for precharge, clearing old output; same-row accesses go straight to the column strobe.
// - Output enable is driven actively, never tied low.
// - Write command is the falling edge of the write strobe.
// - Output enable stays high during writes so memory outputs stay open.
// - Issue 1,024 refreshes every 16 ms.
module edo_dram_ctrl
	import edo_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Request port: one word per request, page kept open for same row
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [19:0] req_addr,
	input  wire logic [1:0]  req_byte_en,
	input  wire logic [15:0] req_wdata,
	// Read data, buffered
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic      [15:0] rd_data,
	// Status
	output logic             mem_ready,
	// DRAM pins
	output logic      [9:0]  dram_addr,
	output logic             row_strobe_n,
	output logic             low_byte_column_strobe_n,
	output logic             high_byte_column_strobe_n,
	output logic             write_strobe_n,
	output logic             output_enable_n,
	input  wire logic [15:0] dram_dq_in,
	output logic      [15:0] dram_dq_out,
	output logic      [15:0] dram_dq_oe
);
	localparam int CW = 16;
	localparam logic [CW-1:0] PAUSE_CYC  = CW'(`WAKE_PAUSE_CYC);
	localparam logic [CW-1:0] GAP_CYC    = CW'(`REFRESH_GAP_CYC);
	localparam logic [3:0]    RP_CYC     = 4'(`RAS_PRECHARGE_CYC);
	localparam logic [3:0]    RAS_CYC    = 4'(`RAS_PULSE_CYC);
	localparam logic [3:0]    RCD_CYC    = 4'(`RAS_CAS_CYC);
	localparam logic [3:0]    CAS_CYC    = 4'(`CAS_PULSE_CYC);
	localparam logic [3:0]    CP_CYC     = 4'(`CAS_PRECHARGE_CYC);
	localparam logic [3:0]    WAKE_COUNT = 4'(`WAKE_REFRESHES);

	// ******************************************************************
	// Pin input synchroniser and read buffer
	// ******************************************************************
	logic [15:0] dq_sync1;
	logic [15:0] dq_sync2;
	logic        fifo_in_ready;
	logic        fifo_push;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			dq_sync1 <= 16'h0000;
			dq_sync2 <= 16'h0000;
		end
		else
		begin
			dq_sync1 <= dram_dq_in;
			dq_sync2 <= dq_sync1;
		end
	end

	edo_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH)) read_buffer
	(
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (dq_sync2),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// ******************************************************************
	// Sequencer
	// ******************************************************************
	ctrl_state_t state;
	ctrl_state_t next_state;
	logic [CW-1:0] timer;
	logic [CW-1:0] next_timer;
	logic [CW-1:0] ref_timer;
	logic [CW-1:0] next_ref_timer;
	logic [3:0]    wake_left;
	logic [3:0]    next_wake_left;
	logic [9:0]    open_row;
	logic [9:0]    next_open_row;
	logic [19:0]   cur_addr;
	logic [19:0]   next_cur_addr;
	logic [15:0]   cur_wdata;
	logic [15:0]   next_cur_wdata;
	logic [1:0]    cur_be;
	logic [1:0]    next_cur_be;
	logic          cur_write;
	logic          next_cur_write;
	logic          ref_due;
	logic          next_ref_due;
	logic          ref_late;
	logic          ready;
	logic          next_ready;
	logic [9:0]    next_dram_addr;
	logic          next_ras_n;
	logic          next_low_byte_column_strobe_n_n;
	logic          next_high_byte_column_strobe_n_n;
	logic          next_we_n;
	logic          next_oe_n;
	logic [15:0]   next_dq_out;
	logic [15:0]   next_dq_oe;
	logic          take;

	// A new word is taken only in idle or with the row open, and with room to buffer a read
	assign req_ready = (state == ST_ROW_OPEN || state == ST_IDLE) && ready && !ref_due
		&& fifo_in_ready && timer == '0;
	assign take      = req_valid && req_ready;
	assign mem_ready = ready;
	// Read pushed the cycle after the column strobe rises, taking pins from two cycles earlier through the synchroniser
	assign fifo_push = state == ST_COL_HIGH && !cur_write && timer == CP_CYC - 4'd1;

	always_comb
	begin
		next_state      = state;
		next_timer      = (timer != '0) ? timer - 1'b1 : timer;
		next_ref_timer  = (ref_timer > CW'(1)) ? ref_timer - 1'b1 : GAP_CYC;
		next_wake_left  = wake_left;
		next_open_row   = open_row;
		next_cur_addr   = cur_addr;
		next_cur_wdata  = cur_wdata;
		next_cur_be     = cur_be;
		next_cur_write  = cur_write;
		next_ref_due    = ref_due || ref_timer == CW'(1);
		next_ready      = ready;
		next_dram_addr  = dram_addr;
		next_ras_n      = row_strobe_n;
		next_low_byte_column_strobe_n_n     = low_byte_column_strobe_n;
		next_high_byte_column_strobe_n_n     = high_byte_column_strobe_n;
		next_we_n       = write_strobe_n;
		next_oe_n       = output_enable_n;
		next_dq_out     = dram_dq_out;
		next_dq_oe      = dram_dq_oe;
		ref_late        = ref_due && ref_timer == CW'(1);
		// Second interval elapsed with refresh still pending: data not trusted
		if (ref_late && ready)
		begin
			next_ready     = 1'b0;
			next_wake_left = WAKE_COUNT;
		end
		unique case (state)
			ST_WAKE_PAUSE:
				if (timer == '0)
				begin
					next_state = ST_PRECHARGE;
					next_timer = CW'(RP_CYC);
				end
			ST_IDLE, ST_ROW_OPEN:
				if (timer == '0)
				begin
					if (ref_due || !ready)
					begin
						// Close any open page before refreshing
						next_ras_n = 1'b1;
						next_state = ST_PRECHARGE;
						next_timer = CW'(RP_CYC);
					end
					else if (take)
					begin
						next_cur_addr  = req_addr;
						next_cur_wdata = req_wdata;
						next_cur_be    = req_byte_en;
						next_cur_write = req_write;
						if (state == ST_ROW_OPEN && req_addr[19:10] == open_row)
						begin
							next_dram_addr = req_addr[9:0];
							next_state     = ST_COL_LOW;
							next_timer     = '0;
						end
						else if (state == ST_ROW_OPEN)
						begin
							next_ras_n = 1'b1;
							next_state = ST_PRECHARGE;
							next_timer = CW'(RP_CYC);
						end
						else
						begin
							// Row address set up one cycle ahead of the strobe
							next_dram_addr = req_addr[19:10];
							next_open_row  = req_addr[19:10];
							next_state     = ST_ROW_OPEN;
							next_timer     = CW'(RCD_CYC);
						end
					end
				end
				else if (state == ST_ROW_OPEN && timer == CW'(1))
				begin
					next_dram_addr = cur_addr[9:0];
					next_state     = ST_COL_LOW;
				end
			ST_PRECHARGE:
			begin
				// Both strobes high for the full precharge clears stale output
				next_ras_n  = 1'b1;
				next_low_byte_column_strobe_n_n = 1'b1;
				next_high_byte_column_strobe_n_n = 1'b1;
				next_oe_n   = 1'b1;
				next_we_n   = 1'b1;
				next_dq_oe  = 16'h0000;
				if (timer == '0)
				begin
					if (ref_due || !ready)
					begin
						// Column-first refresh: address and enables ignored
						next_low_byte_column_strobe_n_n = 1'b0;
						next_high_byte_column_strobe_n_n = 1'b0;
						next_state  = ST_REF_CAS;
						next_timer  = CW'(1);
					end
					else if (cur_addr[19:10] != open_row && ready && row_strobe_n)
					begin
						next_dram_addr = cur_addr[19:10];
						next_open_row  = cur_addr[19:10];
						next_state     = ST_ROW_OPEN;
						next_timer     = CW'(RCD_CYC);
					end
					else
						next_state = ST_IDLE;
				end
			end
			ST_REF_CAS:
				if (timer == '0)
				begin
					next_ras_n = 1'b0;
					next_state = ST_REF_RAS;
					next_timer = CW'(RAS_CYC);
				end
			ST_REF_RAS:
				if (timer == '0)
				begin
					next_ras_n  = 1'b1;
					next_low_byte_column_strobe_n_n = 1'b1;
					next_high_byte_column_strobe_n_n = 1'b1;
					next_state  = ST_REF_END;
					next_timer  = CW'(RP_CYC);
				end
			ST_REF_END:
				if (timer == '0)
				begin
					next_ref_due   = 1'b0;
					next_ref_timer = GAP_CYC;
					if (!ready)
					begin
						next_wake_left = wake_left - 4'd1;
						if (wake_left == 4'd1)
							next_ready = 1'b1;
					end
					next_state    = ST_IDLE;
					next_open_row = ~cur_addr[19:10];
				end
			ST_COL_LOW:
			begin
				// Row strobe already low here; it fell one cycle after the row address was set
				next_ras_n = 1'b0;
				next_low_byte_column_strobe_n_n = !cur_be[0];
				next_high_byte_column_strobe_n_n = !cur_be[1];
				if (cur_write)
				begin
					// Early write: write strobe low with the column strobe
					next_we_n   = 1'b0;
					next_oe_n   = 1'b1;
					next_dq_out = cur_wdata;
					next_dq_oe  = {{8{cur_be[1]}}, {8{cur_be[0]}}};
				end
				else
				begin
					next_we_n  = 1'b1;
					next_oe_n  = 1'b0;
					next_dq_oe = 16'h0000;
				end
				next_state = ST_COL_HIGH;
				next_timer = CW'(CAS_CYC) + CW'(CP_CYC);
			end
			ST_COL_HIGH:
				if (timer == CW'(CP_CYC))
				begin
					next_low_byte_column_strobe_n_n = 1'b1;
					next_high_byte_column_strobe_n_n = 1'b1;
					next_we_n   = 1'b1;
					next_oe_n   = 1'b1;
					next_dq_oe  = 16'h0000;
				end
				else if (timer == '0)
					next_state = ST_ROW_OPEN;
			default:
				next_state = ST_WAKE_PAUSE;
		endcase
		if (state == ST_ROW_OPEN && row_strobe_n && timer == CW'(RCD_CYC))
			next_ras_n = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state                     <= ST_WAKE_PAUSE;
			timer                     <= PAUSE_CYC;
			ref_timer                 <= GAP_CYC;
			wake_left                 <= WAKE_COUNT;
			open_row                  <= 10'h000;
			cur_addr                  <= 20'h00000;
			cur_wdata                 <= 16'h0000;
			cur_be                    <= 2'h0;
			cur_write                 <= 1'b0;
			ref_due                   <= 1'b0;
			ready                     <= 1'b0;
			dram_addr                 <= 10'h000;
			row_strobe_n              <= 1'b1;
			low_byte_column_strobe_n  <= 1'b1;
			high_byte_column_strobe_n <= 1'b1;
			write_strobe_n            <= 1'b1;
			output_enable_n           <= 1'b1;
			dram_dq_out               <= 16'h0000;
			dram_dq_oe                <= 16'h0000;
		end
		else
		begin
			state                     <= next_state;
			timer                     <= next_timer;
			ref_timer                 <= next_ref_timer;
			wake_left                 <= next_wake_left;
			open_row                  <= next_open_row;
			cur_addr                  <= next_cur_addr;
			cur_wdata                 <= next_cur_wdata;
			cur_be                    <= next_cur_be;
			cur_write                 <= next_cur_write;
			ref_due                   <= next_ref_due;
			ready                     <= next_ready;
			dram_addr                 <= next_dram_addr;
			row_strobe_n              <= next_ras_n;
			low_byte_column_strobe_n  <= next_low_byte_column_strobe_n_n;
			high_byte_column_strobe_n <= next_high_byte_column_strobe_n_n;
			write_strobe_n            <= next_we_n;
			output_enable_n           <= next_oe_n;
			dram_dq_out               <= next_dq_out;
			dram_dq_oe                <= next_dq_oe;
		end
	end
endmodule
`default_nettype wire

// file: rtl/edo_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and an active-high asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module edo_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_comb
	begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage is not reset; only words counted as valid are ever read
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule
`default_nettype wire

// file: tb/edo_dram_ctrl_props.sv
// Pin sequencing checks for the EDO controller.
// Assumes binding onto edo_dram_ctrl; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module edo_dram_ctrl_props
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Request side
	input wire logic        req_ready,
	input wire logic        mem_ready,
	// DRAM pins
	input wire logic [9:0]  dram_addr,
	input wire logic        row_strobe_n,
	input wire logic        low_byte_column_strobe_n,
	input wire logic        high_byte_column_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        output_enable_n,
	input wire logic [15:0] dram_dq_oe
);
	wire lc_n = low_byte_column_strobe_n;
	wire hc_n = high_byte_column_strobe_n;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_ready_after_wake: assert property (req_ready |-> mem_ready)
		else $error("request offered before wake-up done");
	a_write_oe_high: assert property (!write_strobe_n |-> output_enable_n)
		else $error("output enable low during write");
	a_drive_oe_off: assert property (|dram_dq_oe |-> output_enable_n)
		else $error("data bus driven while memory outputs enabled");
	a_early_write: assert property ($fell(write_strobe_n) |-> $past(lc_n) && $past(hc_n))
		else $error("write strobe fell after a column strobe");
	a_refresh_both: assert property ($fell(row_strobe_n) |-> lc_n == hc_n)
		else $error("column strobes split at row strobe fall");
	a_refresh_hold: assert property ($fell(row_strobe_n) && !lc_n |-> (!row_strobe_n) [*8])
		else $error("refresh row pulse too short");
	a_row_precharge: assert property ($rose(row_strobe_n) |-> row_strobe_n [*5])
		else $error("row precharge too short");
	a_col_addr_setup: assert property ($fell(lc_n) && !row_strobe_n |-> $stable(dram_addr))
		else $error("column address changed at column strobe fall");
endmodule
bind edo_dram_ctrl edo_dram_ctrl_props i_props
(
	.sys_clk(sys_clk), .rst(rst), .req_ready(req_ready), .mem_ready(mem_ready),
	.dram_addr(dram_addr), .row_strobe_n(row_strobe_n),
	.low_byte_column_strobe_n(low_byte_column_strobe_n),
	.high_byte_column_strobe_n(high_byte_column_strobe_n),
	.write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .dram_dq_oe(dram_dq_oe)
);
`default_nettype wire

// file: tb/edo_dram_ctrl_tb.sv
// Self-checking bench for the EDO DRAM controller.
// Assumes the behavioural DRAM model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module edo_dram_ctrl_tb;
	logic        sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, rd_ready = 1'b0;
	logic [19:0] req_addr = 20'h0;
	logic [1:0]  req_byte_en = 2'h3;
	logic [15:0] req_wdata = 16'h0;
	logic        req_ready, rd_valid, mem_ready, rs_n, lc_n, hc_n, we_n, oe_n;
	logic [15:0] rd_data, dq_in, dq_out, dq_oe;
	logic [9:0]  addr;
	int          num_errors = 0, n_checks = 0, refresh_count;
	realtime     first_fall;
	always #4 sys_clk = ~sys_clk;
	edo_dram_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_byte_en(req_byte_en), .req_wdata(req_wdata), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .mem_ready(mem_ready), .dram_addr(addr),
		.row_strobe_n(rs_n), .low_byte_column_strobe_n(lc_n), .high_byte_column_strobe_n(hc_n),
		.write_strobe_n(we_n), .output_enable_n(oe_n), .dram_dq_in(dq_in),
		.dram_dq_out(dq_out), .dram_dq_oe(dq_oe));
	edo_dram_model i_mem (.sys_clk(sys_clk), .dram_addr(addr), .row_strobe_n(rs_n),
		.low_byte_column_strobe_n(lc_n), .high_byte_column_strobe_n(hc_n),
		.write_strobe_n(we_n), .output_enable_n(oe_n), .dram_dq_out(dq_out),
		.dram_dq_oe(dq_oe), .dram_dq_in(dq_in), .refresh_count(refresh_count),
		.first_fall(first_fall));
	// ****
	// Shared tasks
	// ****
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task timed_out(input string what);
		num_errors++;
		$display("wrong value %s expected done seen timeout", what);
		print_verdict();
	endtask
	task do_req(input logic wr, input logic [19:0] a, input logic [1:0] be, input logic [15:0] d);
		int n;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_byte_en = be;
		req_wdata = d;
		for (n = 0; n < 400 && req_ready !== 1'b1; n++)
			@(negedge sys_clk);
		if (n == 400) timed_out("request");
		@(negedge sys_clk);
		req_valid = 1'b0;
	endtask
	task get_rd(input logic [15:0] e);
		int n;
		@(negedge sys_clk);
		rd_ready = 1'b1;
		for (n = 0; n < 400 && rd_valid !== 1'b1; n++)
			@(negedge sys_clk);
		if (n == 400) timed_out("read");
		`CHECK("read data", e, rd_data)
		@(negedge sys_clk);
		rd_ready = 1'b0;
	endtask
	// ****
	// Scenarios
	// ****
	task t_wake;
		int n;
		`CHECK("bus drive at reset", 16'h0, dq_oe)
		for (n = 0; n < 30000; n++)
		begin
			@(posedge sys_clk);
			if (mem_ready === 1'b1) break;
		end
		if (n == 30000) timed_out("wake");
		`CHECK("wake refreshes", 8, refresh_count)
		`CHECK("wake pause", 1'b1, first_fall >= 200000.0)
	endtask
	task t_bytes;
		do_req(1'b1, 20'h00501, 2'h3, 16'h1234);
		do_req(1'b1, 20'h00501, 2'h1, 16'h77ab);
		do_req(1'b1, 20'h00502, 2'h2, 16'hcd99);
		do_req(1'b0, 20'h00501, 2'h3, 16'h0);
		get_rd(16'h12ab);
		do_req(1'b0, 20'h00502, 2'h3, 16'h0);
		get_rd(16'hcd00);
	endtask
	task t_page;
		do_req(1'b1, 20'h00c01, 2'h3, 16'h5a5a);
		do_req(1'b0, 20'h00501, 2'h3, 16'h0);
		get_rd(16'h12ab);
		do_req(1'b0, 20'h00c01, 2'h3, 16'h0);
		get_rd(16'h5a5a);
	endtask
	task t_fifo;
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 8; i++)
			do_req(1'b0, i[0] ? 20'h00c01 : 20'h00501, 2'h3, 16'h0);
		repeat (20) @(negedge sys_clk);
		req_valid = 1'b1;
		repeat (40)
		begin
			@(posedge sys_clk);
			if (req_ready === 1'b1) seen = 1'b1;
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
		`CHECK("full buffer refusal", 1'b0, seen)
		for (int i = 0; i < 8; i++)
			get_rd(i[0] ? 16'h5a5a : 16'h12ab);
	endtask
	task t_refresh;
		int c0;
		c0 = refresh_count;
		repeat (2100) @(posedge sys_clk);
		`CHECK("periodic refresh", 1'b1, refresh_count > c0)
		`CHECK("ready kept", 1'b1, mem_ready)
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		t_wake();
		t_bytes();
		t_page();
		t_fifo();
		t_refresh();
		print_verdict();
	end
endmodule
`default_nettype wire

// file: tb/edo_dram_model.sv
// Behavioural 1M x 16 EDO DRAM for the controller bench.
// Assumes registered strobes; pins are sampled at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module edo_dram_model
(
	input wire logic        sys_clk,
	input wire logic [9:0]  dram_addr,
	input wire logic        row_strobe_n,
	input wire logic        low_byte_column_strobe_n,
	input wire logic        high_byte_column_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        output_enable_n,
	input wire logic [15:0] dram_dq_out,
	input wire logic [15:0] dram_dq_oe,
	output logic     [15:0] dram_dq_in,
	output int              refresh_count,
	output realtime         first_fall
);
	logic [15:0] mem [int];
	logic [9:0]  row = 10'h0;
	logic [15:0] rdata = 16'h0;
	logic        prev_r = 1'b1, prev_l = 1'b1, prev_h = 1'b1, refr = 1'b0;
	logic [15:0] drv;
	int          key;
	wire lc_n = low_byte_column_strobe_n;
	wire hc_n = high_byte_column_strobe_n;
	initial refresh_count = 0;
	initial first_fall = 0.0;
	// Sampling off the launch edge avoids racing two strobes that move together
	always @(negedge sys_clk)
	begin
		if (prev_r && !row_strobe_n)
		begin
			if (first_fall == 0.0)
				first_fall = $realtime;
			refr = !lc_n;
			if (refr)
				refresh_count++;
			else
				row = dram_addr;
		end
		if (row_strobe_n)
			refr = 1'b0;
		if (!row_strobe_n && !refr && ((prev_l && !lc_n) || (prev_h && !hc_n)))
		begin
			key = {row, dram_addr};
			if (!mem.exists(key))
				mem[key] = 16'h0;
			if (!write_strobe_n)
			begin
				if (!lc_n) mem[key][7:0] = dram_dq_out[7:0];
				if (!hc_n) mem[key][15:8] = dram_dq_out[15:8];
			end
			else
				rdata = mem[key];
		end
		prev_r = row_strobe_n;
		prev_l = lc_n;
		prev_h = hc_n;
	end
	// Released lanes show the inverse of the last read so stale data never matches
	assign drv = {{8{!hc_n}}, {8{!lc_n}}} & {16{!output_enable_n && write_strobe_n && !refr}};
	assign dram_dq_in = (dram_dq_oe & dram_dq_out) | (~dram_dq_oe & drv & rdata)
		| (~dram_dq_oe & ~drv & ~rdata);
endmodule
`default_nettype wire
